/* rtl/mps_top.sv */
// Power control and power-up sequencer of the modem, with APB registers.
// Assumes pins arrive asynchronously; APB master runs on clk_sys.
//
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "mps_params.svh"
// How it works
// - Power request with supply present starts the power-up sequence
// - Shutdown command waits until power request is also dropped
// - Dropping power request detaches from network before the off state
// - Supply loss resets the sequencer to off, keeping the saved flag, without de-registration
// - CPU reset released only after supply detector plus reset delay
// - Host reset input forces a reset while supply stays applied
// - CPU starts initialising only after host reset is released
// - Clear-to-send pulses briefly during CPU boot
// - Native and serial interfaces activate only after initialisation
// - After initialisation data-set-ready asserts, then link setup starts
// - Clear-to-send asserts after command interface is ready
// - Carrier-detect asserts after network registration acknowledge
// - Four power states: off, sleep, receive, transmit
// - A control disables the indicator LEDs, except the start-up and power-down flashes
// - LEDs flash at start-up, receive and transmit flash at power-down
// - Transmit burst lasts 32ms to 7s, or up to 20s at low rate
// - Transmit duty cycle never exceeds 30 percent
// - Host reset, handshake lines, LEDs and CPU reset are active low
// - Power-down drops carrier-detect, saves settings, then data-set-ready
// - Host reset after shutdown gives a cold start, discarding settings
module mps_top #(
  parameter int unsigned RST_DELAY = `MPS_RST_DELAY_CYC,
  parameter int unsigned CTS_PULSE = `MPS_CTS_PULSE_CYC,
  parameter int unsigned FLASH_HALF = `MPS_FLASH_CYC,
  parameter int unsigned TX_MIN = `MPS_TX_MIN_CYC,
  parameter int unsigned TX_MAX_HI = `MPS_TX_MAX_HI_CYC,
  parameter int unsigned TX_MAX_LO = `MPS_TX_MAX_LO_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic host_power_request,
  input wire logic host_reset_n,
  input wire logic supply_ok,
  output logic cpu_reset_n,
  output logic cts_n,
  output logic dsr_n,
  output logic dcd_n,
  output logic [2:0] led_n,
  output logic native_if_active,
  output logic serial_if_active,
  output logic radio_rx,
  output logic radio_tx,
  output logic [1:0] power_state
);
  mps_if mif();

  generate
    if (RST_DELAY < 1 || CTS_PULSE < 1 || FLASH_HALF < 1) begin : g_bad
      $error("Sequencer counts must be at least one cycle");
    end
  endgenerate

  mps_tx_guard #(
    .TX_MIN(TX_MIN),
    .TX_MAX_HI(TX_MAX_HI),
    .TX_MAX_LO(TX_MAX_LO)
  ) u_guard (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .mif(mif.guard)
  );

  // Pin synchronisers
  logic [2:0] sync1, sync2;
  logic pwr_req, hrst_n, sup_ok;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
    end else begin
      sync1 <= {supply_ok, host_reset_n, host_power_request};
      sync2 <= sync1;
    end
  end
  assign pwr_req = sync2[0];
  assign hrst_n = sync2[1];
  assign sup_ok = sync2[2];

  function automatic logic [1:0] reg_sel(input logic [7:0] a);
    case (a)
      `MPS_OFF_CTRL: reg_sel = 2'h0;
      `MPS_OFF_EVENT: reg_sel = 2'h1;
      `MPS_OFF_STATUS: reg_sel = 2'h2;
      default: reg_sel = 2'h3;
    endcase
  endfunction

  // Sequencer state
  mps_pkg::mps_state_t state, next_state;
  logic [31:0] cnt, next_cnt, fcnt, next_fcnt;
  logic cmd_up, next_cmd_up, net_up, next_net_up;
  logic shut_pend, next_shut_pend, saved, next_saved, blink, next_blink;
  logic next_cpu_reset_n, next_cts_n, next_dsr_n, next_dcd_n, next_if_active;
  logic next_radio_rx;
  logic [2:0] next_led_n, led_on;
  logic [1:0] next_power_state;
  logic linked;

  // Bus state
  logic [3:0] ctrl, next_ctrl;
  logic [6:0] evt;
  logic [31:0] next_prdata, status;
  logic next_pready, next_pslverr, wr;

  assign status = {19'h0, sup_ok, hrst_n, pwr_req, mif.tx_on, net_up, cmd_up,
                   saved, shut_pend, power_state, state};

  always_comb begin
    next_pready = psel && penable && !pready;
    next_prdata = prdata;
    next_pslverr = 1'b0;
    next_ctrl = ctrl;
    evt = 7'h00;
    wr = psel && penable && pready && pwrite && !pslverr;
    if (next_pready) begin
      next_pslverr = reg_sel(paddr) == 2'h3;
      unique case (reg_sel(paddr))
        2'h0: next_prdata = {28'h0000000, ctrl};
        2'h2: next_prdata = status;
        default: next_prdata = 32'h0000_0000;
      endcase
    end
    if (wr && reg_sel(paddr) == 2'h0) begin
      next_ctrl = pwdata[3:0];
    end
    if (wr && reg_sel(paddr) == 2'h1) begin
      evt = pwdata[6:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      ctrl <= `MPS_CTRL_RESET;
    end else begin
      pready <= next_pready;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
      ctrl <= next_ctrl;
    end
  end

  assign mif.tx_req = ctrl[`MPS_CTRL_TX_REQ];
  assign mif.low_rate = ctrl[`MPS_CTRL_LOW_RATE];
  assign mif.enable = state == mps_pkg::st_link;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_cmd_up = cmd_up;
    next_net_up = net_up;
    next_saved = saved;
    if (!sup_ok) begin
      next_state = mps_pkg::st_off;
      next_cnt = 32'h0000_0000;
      next_cmd_up = 1'b0;
      next_net_up = 1'b0;
    end else if (!hrst_n) begin
      next_state = pwr_req ? mps_pkg::st_reset : mps_pkg::st_off;
      next_cnt = 32'h0000_0000;
      next_cmd_up = 1'b0;
      next_net_up = 1'b0;
      next_saved = 1'b0;
    end else begin
      unique case (state)
        mps_pkg::st_off: begin
          next_cnt = 32'h0000_0000;
          if (pwr_req) next_state = mps_pkg::st_reset;
        end
        mps_pkg::st_reset: begin
          if (!pwr_req) begin
            next_state = mps_pkg::st_off;
          end else if (cnt >= RST_DELAY - 1) begin
            next_state = mps_pkg::st_boot;
            next_cnt = 32'h0000_0000;
          end else begin
            next_cnt = cnt + 32'h0000_0001;
          end
        end
        mps_pkg::st_boot: begin
          if (cnt < CTS_PULSE) next_cnt = cnt + 32'h0000_0001;
          if (!pwr_req) next_state = mps_pkg::st_off;
          else if (evt[`MPS_EVT_BOOT]) next_state = mps_pkg::st_init;
        end
        mps_pkg::st_init: begin
          if (!pwr_req) next_state = mps_pkg::st_off;
          else if (evt[`MPS_EVT_INIT]) next_state = mps_pkg::st_link;
        end
        mps_pkg::st_link: begin
          if (evt[`MPS_EVT_CMD]) next_cmd_up = 1'b1;
          if (evt[`MPS_EVT_NET]) next_net_up = 1'b1;
          if (!pwr_req) next_state = mps_pkg::st_dereg;
        end
        mps_pkg::st_dereg: begin
          if (evt[`MPS_EVT_DEREG]) begin
            next_net_up = 1'b0;
            next_state = mps_pkg::st_save;
          end
        end
        mps_pkg::st_save: begin
          if (evt[`MPS_EVT_SAVE]) begin
            next_saved = 1'b1;
            next_cmd_up = 1'b0;
            next_state = mps_pkg::st_off;
          end
        end
        default: next_state = mps_pkg::st_off;
      endcase
    end
    next_shut_pend = shut_pend;
    if (next_state == mps_pkg::st_off) next_shut_pend = 1'b0;
    if (evt[`MPS_EVT_SHUT]) next_shut_pend = 1'b1;
    next_fcnt = fcnt + 32'h0000_0001;
    next_blink = blink;
    if (fcnt >= FLASH_HALF - 1) begin
      next_fcnt = 32'h0000_0000;
      next_blink = !blink;
    end
    linked = next_state == mps_pkg::st_link || next_state == mps_pkg::st_dereg
             || next_state == mps_pkg::st_save;
    next_cpu_reset_n = !(next_state == mps_pkg::st_off || next_state == mps_pkg::st_reset);
    next_cts_n = !((next_state == mps_pkg::st_boot && next_cnt < CTS_PULSE)
                   || (linked && next_cmd_up));
    next_dsr_n = !linked;
    next_dcd_n = !next_net_up;
    next_if_active = linked;
    next_radio_rx = linked && ctrl[`MPS_CTRL_RX_EN];
    if (!next_cpu_reset_n) next_power_state = mps_pkg::ps_off;
    else if (mif.tx_on) next_power_state = mps_pkg::ps_transmit;
    else if (next_radio_rx) next_power_state = mps_pkg::ps_receive;
    else next_power_state = mps_pkg::ps_sleep;
    if (next_state == mps_pkg::st_boot) begin
      led_on = {3{next_blink}};
    end else if (next_state == mps_pkg::st_dereg || next_state == mps_pkg::st_save) begin
      led_on = {1'b0, next_blink, next_blink};
    end else if (ctrl[`MPS_CTRL_LED_DIS]) begin
      led_on = 3'h0;
    end else begin
      led_on = {linked, mif.tx_on, next_radio_rx};
    end
    next_led_n = ~led_on;
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state <= mps_pkg::st_off;
      cnt <= 32'h0000_0000;
      fcnt <= 32'h0000_0000;
      blink <= 1'b0;
      cmd_up <= 1'b0;
      net_up <= 1'b0;
      shut_pend <= 1'b0;
      saved <= 1'b0;
      cpu_reset_n <= 1'b0;
      cts_n <= 1'b1;
      dsr_n <= 1'b1;
      dcd_n <= 1'b1;
      led_n <= 3'h7;
      native_if_active <= 1'b0;
      serial_if_active <= 1'b0;
      radio_rx <= 1'b0;
      radio_tx <= 1'b0;
      power_state <= mps_pkg::ps_off;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      fcnt <= next_fcnt;
      blink <= next_blink;
      cmd_up <= next_cmd_up;
      net_up <= next_net_up;
      shut_pend <= next_shut_pend;
      saved <= next_saved;
      cpu_reset_n <= next_cpu_reset_n;
      cts_n <= next_cts_n;
      dsr_n <= next_dsr_n;
      dcd_n <= next_dcd_n;
      led_n <= next_led_n;
      native_if_active <= next_if_active;
      serial_if_active <= next_if_active;
      radio_rx <= next_radio_rx;
      radio_tx <= mif.tx_on;
      power_state <= next_power_state;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  AST_PWR_UP: assert property (
    state == mps_pkg::st_off && sup_ok && hrst_n && pwr_req |=> state == mps_pkg::st_reset)
    else $error("Power request did not start power-up");
  AST_SHUT_WAIT: assert property (
    state == mps_pkg::st_link && shut_pend && pwr_req && sup_ok && hrst_n
    |=> state == mps_pkg::st_link)
    else $error("Shutdown command acted without power request drop");
  AST_DEREG_FIRST: assert property (
    state == mps_pkg::st_link && !pwr_req && sup_ok && hrst_n
    |=> state == mps_pkg::st_dereg && !dsr_n)
    else $error("Power-down skipped network detach");
  AST_SUPPLY_LOSS: assert property (
    !sup_ok |=> state == mps_pkg::st_off && !cpu_reset_n && dsr_n && dcd_n)
    else $error("Supply loss did not reset the sequencer");
  AST_RST_DELAY: assert property (
    $rose(cpu_reset_n) |-> $past(state) == mps_pkg::st_reset && $past(cnt) == RST_DELAY - 1)
    else $error("CPU reset released without full delay");
  AST_HOST_RESET: assert property (
    !hrst_n |=> !cpu_reset_n ##1 !cpu_reset_n)
    else $error("CPU left reset while host reset held");
  AST_CTS_PULSE: assert property (
    $rose(state == mps_pkg::st_boot) |-> !cts_n ##1 (state != mps_pkg::st_boot || !cts_n))
    else $error("Boot pulse on clear-to-send missing");
  AST_IF_ACTIVE: assert property (
    serial_if_active |-> state inside {mps_pkg::st_link, mps_pkg::st_dereg, mps_pkg::st_save})
    else $error("Interfaces active before initialisation");
  AST_DSR: assert property (
    state == mps_pkg::st_init && evt[`MPS_EVT_INIT] && pwr_req && sup_ok && hrst_n |=> !dsr_n)
    else $error("Data-set-ready not asserted after initialisation");
  AST_CTS_ORDER: assert property (
    state == mps_pkg::st_link && !cts_n |-> cmd_up && !dsr_n)
    else $error("Clear-to-send before command interface ready");
  AST_DCD: assert property (
    $fell(dcd_n) |-> $past(state) == mps_pkg::st_link && $past(evt[`MPS_EVT_NET]))
    else $error("Carrier-detect without network acknowledge");
  AST_DOWN_ORDER: assert property (
    state == mps_pkg::st_save |-> dcd_n && !dsr_n)
    else $error("Power-down order broken");
  AST_LED_FLASH: assert property (
    state == mps_pkg::st_boot |-> led_n[0] == led_n[1] && led_n[1] == led_n[2])
    else $error("Start-up LEDs not flashing together");
  COV_UP: cover property (state == mps_pkg::st_init ##1 state == mps_pkg::st_link);
  COV_DOWN: cover property (state == mps_pkg::st_save ##1 state == mps_pkg::st_off);
  COV_COLD: cover property (saved && !hrst_n ##1 !saved);
endmodule
`default_nettype wire

/* common/mps_params.svh */
// Constants for the modem power sequencer: offsets, fields, times, counts.
// Included by the design modules; holds definitions only.
`ifndef MPS_PARAMS_SVH
`define MPS_PARAMS_SVH

`define MPS_CLK_HZ 10000000
`define MPS_CYC_PER_MS (`MPS_CLK_HZ / 1000)
`define MPS_CYC_PER_US (`MPS_CLK_HZ / 1000000)

`define MPS_TX_MIN_MS 32
`define MPS_TX_MAX_HI_MS 7000
`define MPS_TX_MAX_LO_MS 20000
`define MPS_TX_MIN_CYC (`MPS_TX_MIN_MS * `MPS_CYC_PER_MS)
`define MPS_TX_MAX_HI_CYC (`MPS_TX_MAX_HI_MS * `MPS_CYC_PER_MS)
`define MPS_TX_MAX_LO_CYC (`MPS_TX_MAX_LO_MS * `MPS_CYC_PER_MS)

`define MPS_DUTY_NUM 3
`define MPS_DUTY_DEN 10

`define MPS_RST_DELAY_US 100
`define MPS_RST_DELAY_CYC (`MPS_RST_DELAY_US * `MPS_CYC_PER_US)
`define MPS_CTS_PULSE_US 10
`define MPS_CTS_PULSE_CYC (`MPS_CTS_PULSE_US * `MPS_CYC_PER_US)
`define MPS_FLASH_MS 250
`define MPS_FLASH_CYC (`MPS_FLASH_MS * `MPS_CYC_PER_MS)

`define MPS_OFF_CTRL 8'h00
`define MPS_OFF_EVENT 8'h04
`define MPS_OFF_STATUS 8'h08
`define MPS_CTRL_RESET 4'h0

`define MPS_CTRL_LED_DIS 0
`define MPS_CTRL_LOW_RATE 1
`define MPS_CTRL_RX_EN 2
`define MPS_CTRL_TX_REQ 3

`define MPS_EVT_BOOT 0
`define MPS_EVT_INIT 1
`define MPS_EVT_CMD 2
`define MPS_EVT_NET 3
`define MPS_EVT_DEREG 4
`define MPS_EVT_SAVE 5
`define MPS_EVT_SHUT 6

`endif

/* common/mps_pkg.sv */
// Types of the modem power sequencer.
// Needs nothing from its surroundings.
package mps_pkg;
  typedef enum logic [2:0] {
    st_off = 3'h0,
    st_reset = 3'h1,
    st_boot = 3'h2,
    st_init = 3'h3,
    st_link = 3'h4,
    st_dereg = 3'h5,
    st_save = 3'h6
  } mps_state_t;
  typedef enum logic [1:0] {
    ps_off = 2'h0,
    ps_sleep = 2'h1,
    ps_receive = 2'h2,
    ps_transmit = 2'h3
  } mps_pstate_t;
endpackage

/* common/mps_if.sv */
// Link between the sequencer and its transmit guard.
// Both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface mps_if;
  logic tx_req;
  logic low_rate;
  logic enable;
  logic tx_on;
  modport ctl(output tx_req, output low_rate, output enable, input tx_on);
  modport guard(input tx_req, input low_rate, input enable, output tx_on);
endinterface
`default_nettype wire

/* rtl/mps_tx_guard.sv */
// Transmit burst timer and duty limiter of the modem power sequencer.
// Assumes requests and enable come from logic on clk_sys.
`timescale 1ns/1ps
`default_nettype none
`include "mps_params.svh"
module mps_tx_guard #(
  parameter int unsigned TX_MIN = `MPS_TX_MIN_CYC,
  parameter int unsigned TX_MAX_HI = `MPS_TX_MAX_HI_CYC,
  parameter int unsigned TX_MAX_LO = `MPS_TX_MAX_LO_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  mps_if.guard mif
);
  localparam logic [31:0] DEBT_UP = 32'(`MPS_DUTY_DEN - `MPS_DUTY_NUM);
  localparam logic [31:0] DEBT_DN = 32'(`MPS_DUTY_NUM);

  logic tx_on, next_tx_on;
  logic [31:0] cnt, next_cnt, debt, next_debt, max_cyc;

  generate
    if (TX_MIN < 1 || TX_MAX_HI < TX_MIN || TX_MAX_LO < TX_MIN) begin : g_bad
      $error("Transmit burst limits are inconsistent");
    end
  endgenerate

  always_comb begin
    max_cyc = mif.low_rate ? TX_MAX_LO : TX_MAX_HI;
    next_tx_on = tx_on;
    next_cnt = cnt;
    next_debt = debt;
    if (tx_on) begin
      next_cnt = cnt + 32'h0000_0001;
      next_debt = debt + DEBT_UP;
      if (!mif.enable || (next_cnt >= TX_MIN && (!mif.tx_req || next_cnt >= max_cyc))) begin
        next_tx_on = 1'b0;
      end
    end else begin
      next_cnt = 32'h0000_0000;
      next_debt = (debt >= DEBT_DN) ? debt - DEBT_DN : 32'h0000_0000;
      if (mif.enable && mif.tx_req && debt == 32'h0000_0000) begin
        next_tx_on = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      tx_on <= 1'b0;
      cnt <= 32'h0000_0000;
      debt <= 32'h0000_0000;
    end else begin
      tx_on <= next_tx_on;
      cnt <= next_cnt;
      debt <= next_debt;
    end
  end

  assign mif.tx_on = tx_on;

  AST_BURST_MIN: assert property (@(posedge clk_sys) disable iff (!rst_b)
    $fell(tx_on) |-> !$past(mif.enable) || $past(cnt) + 32'h0000_0001 >= TX_MIN)
    else $error("Transmit burst ended too early");
  AST_BURST_MAX: assert property (@(posedge clk_sys) disable iff (!rst_b)
    tx_on |-> ((mif.low_rate || $past(mif.low_rate)) && cnt < TX_MAX_LO)
      || ((!mif.low_rate || !$past(mif.low_rate)) && cnt < TX_MAX_HI))
    else $error("Transmit burst ran too long");
  AST_DUTY: assert property (@(posedge clk_sys) disable iff (!rst_b)
    $rose(tx_on) |-> $past(debt) == 32'h0000_0000)
    else $error("Transmit started before idle time elapsed");
  COV_BURST: cover property (@(posedge clk_sys) disable iff (!rst_b) $rose(tx_on) ##1 tx_on);
endmodule
`default_nettype wire

/* tb/mps_host_model.sv */
// Terminal host model: power request, host reset and supply pins.
// Assumes bench commands change just after rising edges of clk_sys.
`timescale 1ns/1ps
`default_nettype none
module mps_host_model (
  input wire logic clk_sys,
  input wire logic want_on,
  input wire logic want_supply,
  input wire logic want_reset,
  input wire logic dsr_n,
  input wire logic cts_n,
  output logic host_power_request,
  output logic host_reset_n,
  output logic supply_ok,
  output logic host_may_send
);
  logic hold = 1'h0;
  logic ready = 1'h0;
  assign host_power_request = want_on;
  assign host_reset_n = ~want_reset;
  assign supply_ok = want_supply | hold;
  assign host_may_send = ready;
  always @(posedge clk_sys) begin
    hold <= supply_ok & ~want_on & ~dsr_n;
    ready <= ~dsr_n & (ready | ~cts_n);
  end
endmodule
`default_nettype wire

/* tb/modem_power_sequencer_test.sv */
// Self-checking bench for the modem power sequencer top.
// Assumes design files, package, header and host model compile first.
`timescale 1ns/1ps
`default_nettype none
`include "mps_params.svh"
module modem_power_sequencer_test;
  localparam int unsigned RST_DELAY = 4;
  localparam int unsigned CTS_PULSE = 3;
  localparam int unsigned TX_MIN = 5;
  localparam int unsigned TX_MAX_HI = 20;
  localparam int unsigned TX_MAX_LO = 40;
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic err;
  } mps_row_t;
  mps_row_t rows[8] = '{
    '{1'h1, 8'h00, 32'h5, 32'h0, 1'h0},
    '{1'h0, 8'h00, 32'h0, 32'h5, 1'h0},
    '{1'h0, 8'h04, 32'h0, 32'h0, 1'h0},
    '{1'h1, 8'h08, 32'hFFFF, 32'h0, 1'h0},
    '{1'h0, 8'h08, 32'h0, 32'h800, 1'h0},
    '{1'h1, 8'h0C, 32'h1, 32'h0, 1'h1},
    '{1'h0, 8'h0C, 32'h0, 32'h0, 1'h1},
    '{1'h1, 8'h00, 32'h0, 32'h0, 1'h0}};
  logic clk_sys = 1'h0;
  logic rst_b = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic want_on = 1'h0;
  logic want_supply = 1'h0;
  logic want_reset = 1'h0;
  logic host_power_request;
  logic host_reset_n;
  logic supply_ok;
  logic host_may_send;
  logic cpu_reset_n;
  logic cts_n;
  logic dsr_n;
  logic dcd_n;
  logic [2:0] led_n;
  logic native_if_active;
  logic serial_if_active;
  logic radio_rx;
  logic radio_tx;
  logic [1:0] power_state;
  logic [31:0] rdat;
  logic rerr;
  int n_mismatch = 0;
  int checked = 0;
  int cycles = 0;
  int on_cnt = 0;
  int off_cnt = 0;
  int last_on = 0;
  int last_gap = 0;

  mps_top #(.RST_DELAY(RST_DELAY), .CTS_PULSE(CTS_PULSE), .FLASH_HALF(4), .TX_MIN(TX_MIN),
    .TX_MAX_HI(TX_MAX_HI), .TX_MAX_LO(TX_MAX_LO)) mps_top_inst (.clk_sys(clk_sys),
    .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .host_power_request(host_power_request), .host_reset_n(host_reset_n),
    .supply_ok(supply_ok), .cpu_reset_n(cpu_reset_n), .cts_n(cts_n), .dsr_n(dsr_n),
    .dcd_n(dcd_n), .led_n(led_n), .native_if_active(native_if_active),
    .serial_if_active(serial_if_active), .radio_rx(radio_rx), .radio_tx(radio_tx),
    .power_state(power_state));
  mps_host_model mps_host_model_inst (.clk_sys(clk_sys), .want_on(want_on),
    .want_supply(want_supply), .want_reset(want_reset), .dsr_n(dsr_n), .cts_n(cts_n),
    .host_power_request(host_power_request), .host_reset_n(host_reset_n),
    .supply_ok(supply_ok), .host_may_send(host_may_send));

  always #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  // Transmit burst and gap lengths
  always @(posedge clk_sys) begin
    if (radio_tx === 1'h1) begin
      if (off_cnt > 0) last_gap = off_cnt;
      off_cnt = 0;
      on_cnt++;
    end else begin
      if (on_cnt > 0) last_on = on_cnt;
      on_cnt = 0;
      off_cnt++;
    end
  end

  task automatic give_verdict();
    $display("mismatches %0d, comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'h1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'h1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk_sys);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask
  task automatic wait_state(input logic [2:0] s);
    int n;
    n = 0;
    do begin
      apb(1'h0, `MPS_OFF_STATUS, 32'h0);
      n++;
    end while (rdat[2:0] !== s && n < 60);
    check(rdat[2:0], s);
  endtask
  task automatic wait_cpu();
    for (int n = 0; n < 60 && cpu_reset_n !== 1'h1; n++) @(posedge clk_sys);
  endtask
  task automatic flash(input logic [2:0] m);
    logic on;
    logic off;
    on = 1'h0;
    off = 1'h0;
    repeat (12) begin
      @(posedge clk_sys);
      on |= (led_n & m) == 3'h0;
      off |= (led_n & m) == m;
    end
    check({on, off}, 2'h3);
  endtask
  task automatic power_up();
    want_supply <= 1'h1;
    want_on <= 1'h1;
    wait_state(3'h1);
    wait_cpu();
    for (int i = 0; i < 4; i++) wr(`MPS_OFF_EVENT, 32'h1 << i);
    wait_state(3'h4);
  endtask

  initial begin
    repeat (3) @(posedge clk_sys);
    check({cpu_reset_n, cts_n, dsr_n, dcd_n, led_n, power_state}, 9'h0FC);
    rst_b <= 1'h1;
    @(posedge clk_sys);
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].addr, rows[i].wdata);
      check(rerr, rows[i].err);
      if (!rows[i].wr) check(rdat, rows[i].rdata);
    end
    want_supply <= 1'h1;
    want_on <= 1'h1;
    cyc(4);
    check(cpu_reset_n, 1'h0);
    wait_state(3'h1);
    wait_cpu();
    check({cpu_reset_n, cts_n}, 2'h2);
    cyc(CTS_PULSE + 1);
    check(cts_n, 1'h1);
    flash(3'h7);
    wr(`MPS_OFF_EVENT, 32'h8);
    wr(`MPS_OFF_EVENT, 32'h1);
    cyc(1);
    check({dcd_n, dsr_n, native_if_active, serial_if_active}, 4'hC);
    wr(`MPS_OFF_EVENT, 32'h2);
    cyc(1);
    check({dsr_n, cts_n, native_if_active, serial_if_active}, 4'h7);
    wr(`MPS_OFF_EVENT, 32'h4);
    cyc(1);
    check({cts_n, dcd_n}, 2'h1);
    wr(`MPS_OFF_EVENT, 32'h8);
    cyc(1);
    check({dcd_n, host_may_send}, 2'h1);
    wr(`MPS_OFF_CTRL, 32'h4);
    cyc(1);
    check({power_state, radio_rx}, {mps_pkg::ps_receive, 1'h1});
    wr(`MPS_OFF_CTRL, 32'h0);
    cyc(1);
    check({power_state, radio_rx, led_n}, {mps_pkg::ps_sleep, 4'h3});
    wr(`MPS_OFF_CTRL, 32'h8);
    wr(`MPS_OFF_CTRL, 32'h0);
    cyc(30);
    check(last_on >= TX_MIN, 1'h1);
    wr(`MPS_OFF_CTRL, 32'h9);
    for (int n = 0; n < 100 && radio_tx !== 1'h1; n++) @(posedge clk_sys);
    cyc(1);
    check({power_state, led_n}, {mps_pkg::ps_transmit, 3'h7});
    cyc(250);
    check(last_on <= TX_MAX_HI && last_on > TX_MIN, 1'h1);
    check(10 * last_on <= 3 * (last_on + last_gap), 1'h1);
    wr(`MPS_OFF_CTRL, 32'hB);
    cyc(300);
    check(last_on > TX_MAX_HI && last_on <= TX_MAX_LO, 1'h1);
    wr(`MPS_OFF_CTRL, 32'h1);
    wr(`MPS_OFF_EVENT, 32'h40);
    wait_state(3'h4);
    check(rdat[5], 1'h1);
    want_on <= 1'h0;
    wait_state(3'h5);
    check({dcd_n, dsr_n}, 2'h0);
    flash(3'h3);
    wr(`MPS_OFF_EVENT, 32'h10);
    cyc(1);
    check({dcd_n, dsr_n}, 2'h2);
    wr(`MPS_OFF_EVENT, 32'h20);
    cyc(1);
    check({dsr_n, cts_n, cpu_reset_n, power_state}, 5'h18);
    wait_state(3'h0);
    check(rdat[6], 1'h1);
    power_up();
    want_supply <= 1'h0;
    wait_state(3'h0);
    check({dsr_n, dcd_n, cts_n, cpu_reset_n}, 4'hE);
    power_up();
    want_reset <= 1'h1;
    wait_state(3'h1);
    cyc(3 * RST_DELAY);
    check(cpu_reset_n, 1'h0);
    check(rdat[6], 1'h0);
    want_reset <= 1'h0;
    wait_cpu();
    check(cpu_reset_n, 1'h1);
    want_on <= 1'h0;
    wait_state(3'h0);
    power_up();
    rst_b <= 1'h0;
    cyc(1);
    check({cpu_reset_n, cts_n, dsr_n, dcd_n, led_n, power_state}, 9'h0FC);
    rst_b <= 1'h1;
    @(posedge clk_sys);
    apb(1'h0, `MPS_OFF_CTRL, 32'h0);
    check(rdat, 32'h0);
    give_verdict();
  end
endmodule
`default_nettype wire
